// File: hdl/usr_pkg.sv
`default_nettype none
package usr_pkg;
    localparam logic [7:0]  USR_OFS_EVENT_ENABLES = 8'h68;
    localparam logic [7:0]  USR_OFS_SHORT_WAIT    = 8'h6C;
    localparam logic [7:0]  USR_OFS_FILL_COUNTS   = 8'h70;
    localparam logic [7:0]  USR_OFS_POSITIONS     = 8'h74;

    localparam int          USR_ALWAYS_SEND_BIT   = 31;
    localparam int          USR_MAC_RTO_BIT       = 19;
    localparam int          USR_RX_FRAME_BIT      = 18;
    localparam int          USR_TX_HALT_BIT       = 17;
    localparam int          USR_RX_HALT_BIT       = 16;
    localparam int          USR_XCVR_BIT          = 15;
    localparam int          USR_TX_FAULT_BIT      = 14;
    localparam int          USR_TXQ_UNDER_BIT     = 13;
    localparam int          USR_TXQ_OVER_BIT      = 12;
    localparam int          USR_DROP_BIT          = 11;
    localparam int          USR_PIN_COUNT         = 11;
    localparam logic [31:0] USR_ENABLE_WMASK      = 32'h800F_FFFF;
    localparam logic [31:0] USR_ENABLES_RESET     = 32'h0000_0000;
    localparam int          USR_EVENT_COUNT       = 20;

    localparam int          USR_WAIT_W            = 16;
    localparam logic [15:0] USR_WAIT_RESET        = 16'h0800;
    localparam real         USR_WAIT_UNIT_NS      = 16.667;
    localparam real         USR_CLK_PERIOD_NS     = 8.0;

    localparam int          USR_LVL_W             = 14;
    localparam int          USR_PTR_W             = 13;
    localparam int          USR_RD_LVL_LSB        = 16;
    localparam int          USR_RD_PTR_LSB        = 16;

    localparam logic [1:0]  USR_RESP_OKAY         = 2'h0;
    localparam logic [1:0]  USR_RESP_SLVERR       = 2'h2;
endpackage : usr_pkg
`default_nettype wire

// File: hdl/usr_regs.sv
// Decided for this implementation: register access over AXI4-Lite.
`default_nettype none
// Summary of operation
// - Always-send bit: packet every poll
// - Otherwise packet only after enabled event
// - Bit 19 gates MAC reset timeout
// - Bit 18 gates receive-frame-present
// - Bits 17/16 gate transmitter/receiver halted
// - Bit 15 gates transceiver interrupt
// - Bit 14 gates transmit fault
// - Bits 13/12 gate transmit underflow/overflow
// - Bit 11 gates dropped frame
// - Bits 10:0 gate pin events; reset zero
// - Wait programmed delay before short packet
// - Delay unit 16.667 ns; reset 800h
// - Read fill adds packet words at end
// - Read fill drops one per word read
// - Read rewind restores words read out
// - Write fill adds one per word written
// - Write fill drops packet after full read
// - Write rewind discards partial packet words
// - Read position readable, bits 28:16
// - Write position readable, bits 12:0
module usr_regs
    import usr_pkg::*;
#(
    parameter int LVL_W = USR_LVL_W,
    parameter int PTR_W = USR_PTR_W
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic                     ev_mac_reset_timeout,
    input  wire logic                     ev_rx_frame_present,
    input  wire logic                     ev_transmitter_halted,
    input  wire logic                     ev_receiver_halted,
    input  wire logic                     ev_transceiver,
    input  wire logic                     ev_transmit_fault,
    input  wire logic                     ev_transmit_underflow,
    input  wire logic                     ev_transmit_overflow,
    input  wire logic                     ev_dropped_frame,
    input  wire logic [USR_PIN_COUNT-1:0] ev_pins,
    input  wire logic                     poll_tick,
    output logic                          status_send,
    output logic [USR_EVENT_COUNT-1:0]    status_events,
    input  wire logic                     short_start,
    output logic                          short_go,
    input  wire logic                     rxq_wr_word,
    input  wire logic                     rxq_wr_end,
    input  wire logic                     rxq_wr_rewind,
    input  wire logic                     rxq_rd_word,
    input  wire logic                     rxq_rd_end,
    input  wire logic                     rxq_rd_rewind
);
    // Short-packet wait counted in clk cycles: one field unit is 16.667 ns
    localparam int   WAIT_SCALE_MILLI = int'(USR_WAIT_UNIT_NS * 1000.0 / USR_CLK_PERIOD_NS);
    localparam int   WAIT_CNT_W       = 32;

    typedef struct packed {
        logic                       awready;
        logic                       wready;
        logic                       aw_held;
        logic                       w_held;
        logic [7:0]                 aw_addr;
        logic [31:0]                w_data;
        logic [3:0]                 w_strb;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
        logic [31:0]                enables;
        logic [USR_WAIT_W-1:0]      wait_units;
        logic [USR_EVENT_COUNT-1:0] pending;
        logic                       send;
        logic [USR_EVENT_COUNT-1:0] sent_events;
        logic                       waiting;
        logic [WAIT_CNT_W-1:0]      wait_cnt;
        logic                       go;
        logic [LVL_W-1:0]           rd_fill;
        logic [LVL_W-1:0]           wr_fill;
        logic [LVL_W-1:0]           wr_pkt;
        logic [LVL_W-1:0]           rd_pkt;
        logic [LVL_W-1:0]           done_pkt;
        logic [PTR_W-1:0]           rd_pos;
        logic [PTR_W-1:0]           wr_pos;
        logic [PTR_W-1:0]           wr_pkt_start;
        logic [PTR_W-1:0]           rd_pkt_start;
    } usr_state_s;

    usr_state_s                 st_q;
    usr_state_s                 st_d;
    logic [USR_EVENT_COUNT-1:0] raw_ev;
    logic [USR_EVENT_COUNT-1:0] gated_ev;
    logic [31:0]                wmask;
    logic [31:0]                rd_word;
    logic [7:0]                 rd_addr;

    assign raw_ev = {ev_mac_reset_timeout, ev_rx_frame_present, ev_transmitter_halted,
                     ev_receiver_halted, ev_transceiver, ev_transmit_fault,
                     ev_transmit_underflow, ev_transmit_overflow, ev_dropped_frame, ev_pins};
    // Event vector lines up with enable bits 19:0
    assign gated_ev = raw_ev & st_q.enables[USR_EVENT_COUNT-1:0];

    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            assign wmask[b*8 +: 8] = {8{st_q.w_strb[b]}};
        end
    endgenerate

    assign rd_addr = s_axi_araddr;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_addr)
            USR_OFS_EVENT_ENABLES: rd_word = st_q.enables;
            USR_OFS_SHORT_WAIT:    rd_word[USR_WAIT_W-1:0] = st_q.wait_units;
            USR_OFS_FILL_COUNTS: begin
                rd_word[USR_RD_LVL_LSB +: LVL_W] = st_q.rd_fill;
                rd_word[LVL_W-1:0] = st_q.wr_fill;
            end
            USR_OFS_POSITIONS: begin
                rd_word[USR_RD_PTR_LSB +: PTR_W] = st_q.rd_pos;
                rd_word[PTR_W-1:0] = st_q.wr_pos;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.go = 1'b0;
        st_d.send = 1'b0;

        // Write address and data may arrive in either order
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
            st_d.awready = 1'b0;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
            st_d.wready = 1'b0;
        end
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = USR_RESP_OKAY;
            unique case (st_q.aw_addr)
                USR_OFS_EVENT_ENABLES: st_d.enables = (st_q.enables & ~(wmask & USR_ENABLE_WMASK))
                    | (st_q.w_data & wmask & USR_ENABLE_WMASK);
                USR_OFS_SHORT_WAIT: st_d.wait_units = (st_q.wait_units & ~wmask[15:0])
                    | (st_q.w_data[15:0] & wmask[15:0]);
                USR_OFS_FILL_COUNTS, USR_OFS_POSITIONS: st_d.bresp = USR_RESP_OKAY;
                default: st_d.bresp = USR_RESP_SLVERR;
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready = 1'b1;
        end

        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_word;
            st_d.rresp = (rd_addr == USR_OFS_EVENT_ENABLES || rd_addr == USR_OFS_SHORT_WAIT
                || rd_addr == USR_OFS_FILL_COUNTS || rd_addr == USR_OFS_POSITIONS)
                ? USR_RESP_OKAY : USR_RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // Pending events survive until a poll; a new event at the poll is kept for the next
        if (poll_tick) begin
            st_d.send = st_q.enables[USR_ALWAYS_SEND_BIT] || (|st_q.pending);
            st_d.sent_events = st_q.pending;
            st_d.pending = gated_ev;
        end else begin
            st_d.pending = st_q.pending | gated_ev;
        end

        if (short_start) begin
            st_d.waiting = 1'b1;
            st_d.wait_cnt = WAIT_CNT_W'((64'(st_q.wait_units) * 64'(WAIT_SCALE_MILLI)
                + 64'd999) / 64'd1000);
        end else if (st_q.waiting) begin
            if (st_q.wait_cnt == '0) begin
                st_d.waiting = 1'b0;
                st_d.go = 1'b1;
            end else begin
                st_d.wait_cnt = st_q.wait_cnt - 1'b1;
            end
        end

        // Write side of the receive queue
        if (rxq_wr_rewind) begin
            st_d.wr_fill = st_q.wr_fill - st_q.wr_pkt;
            st_d.wr_pos = st_q.wr_pkt_start;
            st_d.wr_pkt = '0;
        end else if (rxq_wr_word) begin
            st_d.wr_fill = st_q.wr_fill + 1'b1;
            st_d.wr_pos = st_q.wr_pos + 1'b1;
            st_d.wr_pkt = rxq_wr_end ? '0 : st_q.wr_pkt + 1'b1;
            if (rxq_wr_end) begin
                st_d.wr_pkt_start = st_q.wr_pos + 1'b1;
            end
        end
        if (rxq_rd_end && rxq_rd_word && !rxq_rd_rewind) begin
            st_d.wr_fill = st_d.wr_fill - (st_q.rd_pkt + 1'b1);
        end

        // Read side of the receive queue
        if (rxq_rd_rewind) begin
            st_d.rd_fill = st_q.rd_fill + st_q.rd_pkt;
            st_d.rd_pos = st_q.rd_pkt_start;
            st_d.rd_pkt = '0;
        end else if (rxq_rd_word) begin
            st_d.rd_fill = st_q.rd_fill - 1'b1;
            st_d.rd_pos = st_q.rd_pos + 1'b1;
            st_d.rd_pkt = rxq_rd_end ? '0 : st_q.rd_pkt + 1'b1;
            if (rxq_rd_end) begin
                st_d.rd_pkt_start = st_q.rd_pos + 1'b1;
            end
        end
        if (rxq_wr_end && rxq_wr_word && !rxq_wr_rewind) begin
            st_d.rd_fill = st_d.rd_fill + (st_q.wr_pkt + 1'b1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.awready <= 1'b1;
            st_q.wready <= 1'b1;
            st_q.enables <= USR_ENABLES_RESET;
            st_q.wait_units <= USR_WAIT_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign status_send   = st_q.send;
    assign status_events = st_q.sent_events;
    assign short_go      = st_q.go;
endmodule // usr_regs
`default_nettype wire

// File: tb/usr_regs_chk.sv
`default_nettype none
module usr_regs_chk
    import usr_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic [1:0]                 s_axi_bresp,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic [31:0]                s_axi_rdata,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    input wire logic                       poll_tick,
    input wire logic                       status_send,
    input wire logic [USR_EVENT_COUNT-1:0] status_events,
    input wire logic                       short_go
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_send_poll: assert property (status_send |-> $past(poll_tick))
        else $error("status packet without a poll");
    chk_events_held: assert property (!$past(poll_tick) |-> $stable(status_events))
        else $error("reported events changed between polls");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_ar_blocked: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready while answer pending");
    chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
    chk_go_pulse: assert property (short_go |=> !short_go)
        else $error("short packet go longer than a cycle");

    cover property (status_send && status_events != '0);
    cover property (status_send && status_events == '0);
    cover property (short_go);
    cover property (s_axi_bvalid && s_axi_bresp == USR_RESP_SLVERR);
endmodule // usr_regs_chk

bind usr_regs usr_regs_chk usr_regs_chk_inst (.*);
`default_nettype wire

// File: tb/usr_host_model.sv
`default_nettype none
module usr_host_model
    import usr_pkg::*;
#(
    parameter int PERIOD = 16
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       status_send,
    input wire logic [USR_EVENT_COUNT-1:0] status_events,
    output logic                           poll_tick,
    output logic                           seen_send,
    output logic [USR_EVENT_COUNT-1:0]     seen_events,
    output logic [7:0]                     polls
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic       slot_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q       <= '0;
            poll_tick   <= 1'b0;
            slot_q      <= 1'b0;
            seen_send   <= 1'b0;
            seen_events <= '0;
            polls       <= '0;
        end else begin
            cnt_q     <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
            poll_tick <= (cnt_q == 8'(PERIOD - 1));
            slot_q    <= poll_tick;
            // Only the slot after a poll counts; a late packet reads as none
            if (slot_q) begin
                seen_send   <= status_send;
                seen_events <= status_events;
                polls       <= polls + 8'h01;
            end
        end
    end
endmodule // usr_host_model
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench
    import usr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, short_start = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, polls;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, u;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        status_send, short_go, poll_tick, seen_send;
    logic [19:0] status_events, seen_events, ev = '0;
    logic        rxq_wr_word = 0, rxq_wr_end = 0, rxq_wr_rewind = 0;
    logic        rxq_rd_word = 0, rxq_rd_end = 0, rxq_rd_rewind = 0;
    int          err_total = 0, tests_run = 0, cyc = 0, n;

    usr_regs usr_regs_inst (
        .ev_mac_reset_timeout  (ev[USR_MAC_RTO_BIT]),
        .ev_rx_frame_present   (ev[USR_RX_FRAME_BIT]),
        .ev_transmitter_halted (ev[USR_TX_HALT_BIT]),
        .ev_receiver_halted    (ev[USR_RX_HALT_BIT]),
        .ev_transceiver        (ev[USR_XCVR_BIT]),
        .ev_transmit_fault     (ev[USR_TX_FAULT_BIT]),
        .ev_transmit_underflow (ev[USR_TXQ_UNDER_BIT]),
        .ev_transmit_overflow  (ev[USR_TXQ_OVER_BIT]),
        .ev_dropped_frame      (ev[USR_DROP_BIT]),
        .ev_pins               (ev[USR_PIN_COUNT-1:0]),
        .*
    );
    usr_host_model usr_host_model_inst (.*);

    initial forever #4 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        @(posedge clk);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
            if (s_axi_wvalid && s_axi_wready) w = 1'b1;
        end
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask

    task automatic pulse(input logic [19:0] e, input logic [5:0] f);
        @(posedge clk);
        ev <= e;
        {rxq_wr_word, rxq_wr_end, rxq_wr_rewind, rxq_rd_word, rxq_rd_end, rxq_rd_rewind} <= f;
        @(posedge clk);
        ev <= '0;
        {rxq_wr_word, rxq_wr_end, rxq_wr_rewind, rxq_rd_word, rxq_rd_end, rxq_rd_rewind} <= '0;
    endtask

    // Waits for the host to record the next poll
    task automatic pchk(input logic chk_it, input logic s, input logic [19:0] e);
        logic [7:0] p;
        p = polls;
        while (polls === p) @(posedge clk);
        if (chk_it) chk("send", {31'h0, s}, {31'h0, seen_send});
        if (chk_it) chk("events", {12'h0, e}, {12'h0, seen_events});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run needs about 5k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(USR_OFS_EVENT_ENABLES, 32'h0, USR_RESP_OKAY);
        rd(USR_OFS_FILL_COUNTS, 32'h0, USR_RESP_OKAY);
        rd(USR_OFS_POSITIONS, 32'h0, USR_RESP_OKAY);
        axw(USR_OFS_FILL_COUNTS, 32'hFFFF_FFFF, USR_RESP_OKAY);
        rd(USR_OFS_FILL_COUNTS, 32'h0, USR_RESP_OKAY);
        axw(8'h80, 32'h1, USR_RESP_SLVERR);
        rd(8'h80, 32'h0, USR_RESP_SLVERR);
        axw(USR_OFS_EVENT_ENABLES, 32'hFFFF_FFFF, USR_RESP_OKAY);
        rd(USR_OFS_EVENT_ENABLES, 32'h800F_FFFF, USR_RESP_OKAY);
        $display("test registers done");
        for (int k = 0; k < 2; k++) begin
            u = k ? 32'h3 : 32'h800;
            if (k) axw(USR_OFS_SHORT_WAIT, 32'hFFFF_0003, USR_RESP_OKAY);
            rd(USR_OFS_SHORT_WAIT, u, USR_RESP_OKAY);
            @(posedge clk);
            short_start <= 1'b1;
            @(posedge clk);
            short_start <= 1'b0;
            n = 0;
            while (short_go !== 1'b1) begin
                @(posedge clk);
                n++;
            end
            chk("wait_cycles", (u * 2083 + 999) / 1000 + 2, 32'(n));
        end
        $display("test short wait done");
        for (int i = 0; i < 20; i++) begin
            axw(USR_OFS_EVENT_ENABLES, 32'h1 << i, USR_RESP_OKAY);
            pchk(1'b0, 1'b0, 20'h0);
            pulse(20'hF_FFFF, 6'h00);
            // Every other event fires too, so a crossed mask bit shows up here
            pchk(1'b1, 1'b1, 20'h1 << i);
            chk("events_mask", 32'h1 << i, {12'h0, seen_events});
        end
        axw(USR_OFS_EVENT_ENABLES, 32'h0, USR_RESP_OKAY);
        pchk(1'b0, 1'b0, 20'h0);
        pulse(20'hF_FFFF, 6'h00);
        pchk(1'b1, 1'b0, 20'h0);
        axw(USR_OFS_EVENT_ENABLES, 32'h8000_0000, USR_RESP_OKAY);
        pchk(1'b1, 1'b1, 20'h0);
        pchk(1'b1, 1'b1, 20'h0);
        $display("test status events done");
        pulse(20'h0, 6'b100000);
        pulse(20'h0, 6'b100000);
        pulse(20'h0, 6'b110000);
        rd(USR_OFS_FILL_COUNTS, 32'h0003_0003, USR_RESP_OKAY);
        pulse(20'h0, 6'b000100);
        rd(USR_OFS_FILL_COUNTS, 32'h0002_0003, USR_RESP_OKAY);
        rd(USR_OFS_POSITIONS, 32'h0001_0003, USR_RESP_OKAY);
        pulse(20'h0, 6'b000001);
        rd(USR_OFS_FILL_COUNTS, 32'h0003_0003, USR_RESP_OKAY);
        rd(USR_OFS_POSITIONS, 32'h0000_0003, USR_RESP_OKAY);
        pulse(20'h0, 6'b000100);
        pulse(20'h0, 6'b000100);
        pulse(20'h0, 6'b000110);
        rd(USR_OFS_FILL_COUNTS, 32'h0, USR_RESP_OKAY);
        pulse(20'h0, 6'b100000);
        pulse(20'h0, 6'b001000);
        rd(USR_OFS_FILL_COUNTS, 32'h0, USR_RESP_OKAY);
        rd(USR_OFS_POSITIONS, 32'h0003_0003, USR_RESP_OKAY);
        $display("test receive queue done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
